/* verilog/sld_pkg.sv */
// Overview of operation
// - outputs enabled, display off: commons at select, segments at deselect
// - display on: commons scanned in turn, segments follow stored display data
// - output enable and display on may be set in one write
// - blink and area select may change while running, taken up live
// - clearing display on and output enable stops the display
// - internal boost allows only one-third or one-quarter bias
// - capacitor split allows only one-third bias
// - commons selected in turn; static drives commons zero to three alike
// - two-slice leaves commons two, three unused; three-slice leaves three
// - commons four to seven used only in six and eight slice modes
// - eight-slice reads bits 0 to 7, drives segments four to forty-one
// - static to four-slice modes read bits 0-3 or 4-7, drive segments zero to 41
// - data bit one gives select level, zero gives deselect level
// - blink off: area select zero shows A area, one shows B area
// - blink on: A and B areas swap on each periodic rtc pulse
// - six and eight slice modes read bits from zero up, no area choice
// - commons four to seven share pins with segments zero to three
package sld_pkg;
   localparam int ADDR_W    = 12;
   localparam int NUM_SEG   = 42;
   localparam int NUM_COM   = 8;
   localparam int DIV_W     = 8;
   // register byte offsets
   localparam logic [11:0] OFS_MODE0  = 12'h000;
   localparam logic [11:0] OFS_MODE1  = 12'h004;
   localparam logic [11:0] OFS_CLKCTL = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00c;
   localparam logic [11:0] OFS_DATA   = 12'h100;
   // lcd_mode_reg_zero fields
   localparam int M0_METHOD_LO = 0;
   localparam int M0_WAVE      = 2;
   localparam int M0_SLICE_LO  = 3;
   localparam int M0_BIAS_LO   = 6;
   localparam logic [7:0] M0_RESET = 8'h00;
   // lcd_mode_reg_one fields
   localparam int M1_SUPPLY = 0;
   localparam int M1_BOOST  = 1;
   localparam int M1_BLINK  = 2;
   localparam int M1_AREA   = 3;
   localparam int M1_OUTEN  = 4;
   localparam int M1_DISPON = 5;
   localparam logic [7:0] M1_RESET = 8'h00;
   localparam logic [2:0] CLK_RESET = 3'h0;
   // status fields
   localparam int ST_RUN   = 0;
   localparam int ST_AREAB = 1;
   localparam int ST_POL   = 2;
   localparam int ST_IDX   = 4;
   // drive methods
   localparam logic [1:0] DM_RESIST = 2'h0;
   localparam logic [1:0] DM_BOOST  = 2'h1;
   localparam logic [1:0] DM_SPLIT  = 2'h2;
   // bias settings
   localparam logic [1:0] BIAS_THIRD   = 2'h0;
   localparam logic [1:0] BIAS_HALF    = 2'h1;
   localparam logic [1:0] BIAS_QUARTER = 2'h2;
   // time slice codes
   typedef enum logic [2:0] {
      SL_STATIC = 3'h0,
      SL_TWO    = 3'h1,
      SL_THREE  = 3'h2,
      SL_FOUR   = 3'h3,
      SL_SIX    = 3'h4,
      SL_EIGHT  = 3'h5
   } sld_slice_t;
endpackage

/* verilog/sld_tick_gen.sv */
`timescale 1ns/10ps
module sld_tick_gen
   import sld_pkg::*;
#(
   parameter int W = sld_pkg::DIV_W
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [2:0] divSel,
   output logic            lcdTick
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic [W-1:0] limit;

   // period is 2^(divSel+1) core clocks; held at zero while stopped
   always_comb begin
      limit    = W'((1 << (32'(divSel) + 1)) - 1);
      cnt_next = cnt_reg + 1'b1;
      if (!run || cnt_reg == limit) begin
         cnt_next = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign lcdTick = run && (cnt_reg == limit);
endmodule

/* verilog/sld_drive_ctrl.sv */
`timescale 1ns/10ps
module sld_drive_ctrl
   import sld_pkg::*;
(
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [sld_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       rtcPeriodicInterrupt,
   output logic      [sld_pkg::NUM_COM-1:0] comSelect,
   output logic      [sld_pkg::NUM_COM-1:0] comEnable,
   output logic      [sld_pkg::NUM_SEG-1:0] segSelect,
   output logic      [sld_pkg::NUM_SEG-1:0] segEnable,
   output logic                            levelPolarity,
   output logic                            boostEnable,
   output logic                            supplyRange,
   output logic      [1:0]                 driveMethod,
   output logic      [1:0]                 biasSelect,
   output logic                            waveformType
);
   import sld_pkg::*;

   // legal pairing of drive method and bias
   function automatic logic legalPair(input logic [1:0] m,
                                      input logic [1:0] b);
      case (m)
         DM_RESIST: legalPair = (b != 2'h3);
         DM_BOOST:  legalPair = (b == BIAS_THIRD) ||
                                (b == BIAS_QUARTER);
         DM_SPLIT:  legalPair = (b == BIAS_THIRD);
         default:   legalPair = 1'b0;
      endcase
   endfunction

   // last common index of a frame for each slice code
   function automatic logic [2:0] lastCom(input logic [2:0] s);
      case (s)
         SL_STATIC: lastCom = 3'h0;
         SL_TWO:    lastCom = 3'h1;
         SL_THREE:  lastCom = 3'h2;
         SL_FOUR:   lastCom = 3'h3;
         SL_SIX:    lastCom = 3'h5;
         SL_EIGHT:  lastCom = 3'h7;
         default:   lastCom = 3'h0;
      endcase
   endfunction

   function automatic logic wideMode(input logic [2:0] s);
      wideMode = (s == SL_SIX) || (s == SL_EIGHT);
   endfunction

   // ---------------- register bus ----------------
   logic [7:0] mode0_reg;
   logic [7:0] mode0_next;
   logic [7:0] mode1_reg;
   logic [7:0] mode1_next;
   logic [2:0] clkCtl_reg;
   logic [2:0] clkCtl_next;
   logic [7:0] dispData_reg [NUM_SEG];
   logic [7:0] dispData_next [NUM_SEG];
   logic       access;
   logic       isData;
   logic [5:0] dataIdx;
   logic       mapped;
   logic       badPair;
   logic [31:0] rdMux;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   logic [2:0] comIdx_reg;
   logic [2:0] comIdx_next;
   logic       pol_reg;
   logic       pol_next;
   logic       blinkB_reg;
   logic       blinkB_next;
   logic       lcdTick;
   logic       running;
   logic [2:0] slices;
   logic       showB;

   assign access  = psel && penable;
   assign isData  = (paddr >= OFS_DATA) &&
                    (paddr < OFS_DATA + 12'(4 * NUM_SEG)) &&
                    (paddr[1:0] == 2'h0);
   assign dataIdx = 6'((paddr - OFS_DATA) >> 2);
   assign mapped  = isData || paddr == OFS_MODE0 || paddr == OFS_MODE1 ||
                    paddr == OFS_CLKCTL || paddr == OFS_STATUS;
   // a mode write with an illegal method and bias pair is refused
   assign badPair = pwrite && paddr == OFS_MODE0 &&
                    !legalPair(pwdata[M0_METHOD_LO +: 2],
                               pwdata[M0_BIAS_LO +: 2]);
   assign pready  = 1'b1;                                    // zero wait
   assign pslverr = access && (!mapped || badPair);

   // next values of software-visible registers
   always_comb begin
      mode0_next  = mode0_reg;
      mode1_next  = mode1_reg;
      clkCtl_next = clkCtl_reg;
      for (int i = 0; i < NUM_SEG; i++) begin
         dispData_next[i] = dispData_reg[i];
      end
      if (access && pwrite && mapped && !badPair) begin
         if (paddr == OFS_MODE0) begin
            mode0_next = pwdata[7:0];
         end else if (paddr == OFS_MODE1) begin
            // both output bits land in one write
            mode1_next = {2'h0, pwdata[5:0]};
         end else if (paddr == OFS_CLKCTL) begin
            clkCtl_next = pwdata[2:0];
         end else if (isData) begin
            dispData_next[dataIdx] = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode0_reg  <= M0_RESET;
         mode1_reg  <= M1_RESET;
         clkCtl_reg <= CLK_RESET;
         for (int i = 0; i < NUM_SEG; i++) begin
            dispData_reg[i] <= 8'h00;
         end
      end else begin
         mode0_reg  <= mode0_next;
         mode1_reg  <= mode1_next;
         clkCtl_reg <= clkCtl_next;
         for (int i = 0; i < NUM_SEG; i++) begin
            dispData_reg[i] <= dispData_next[i];
         end
      end
   end

   // read mux, zero for unmapped addresses
   always_comb begin
      rdMux = 32'h0000_0000;
      if (paddr == OFS_MODE0) begin
         rdMux[7:0] = mode0_reg;
      end else if (paddr == OFS_MODE1) begin
         rdMux[7:0] = mode1_reg;
      end else if (paddr == OFS_CLKCTL) begin
         rdMux[2:0] = clkCtl_reg;
      end else if (paddr == OFS_STATUS) begin
         rdMux[ST_RUN]      = running;
         rdMux[ST_AREAB]    = showB;
         rdMux[ST_POL]      = pol_reg;
         rdMux[ST_IDX +: 3] = comIdx_reg;
      end else if (isData) begin
         rdMux[7:0] = dispData_reg[dataIdx];
      end
      // caught at the end of the setup cycle, then held, so the word
      // stays steady through the access phase while status moves on
      prdata_next = prdata_reg;
      if (psel && !penable) begin
         prdata_next = rdMux;
      end
   end

   // read data register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;

   // mode fields straight to the analog side
   assign driveMethod  = mode0_reg[M0_METHOD_LO +: 2];
   assign biasSelect   = mode0_reg[M0_BIAS_LO +: 2];
   assign waveformType = mode0_reg[M0_WAVE];
   assign supplyRange  = mode1_reg[M1_SUPPLY];
   // boost is left to software; it must drop outputs first
   assign boostEnable  = mode1_reg[M1_BOOST];

   // ---------------- scan timing ----------------
   // stopped only when both output bits are clear
   assign running = mode1_reg[M1_OUTEN] || mode1_reg[M1_DISPON];
   assign slices  = mode0_reg[M0_SLICE_LO +: 3];

   sld_tick_gen #(
      .W       (DIV_W)
   ) sld_tick_gen_i (
      .core_clk(core_clk),
      .rst     (rst),
      .run     (running),
      .divSel  (clkCtl_reg),
      .lcdTick (lcdTick)
   );

   // common index, frame polarity and blink phase
   always_comb begin
      comIdx_next = comIdx_reg;
      pol_next    = pol_reg;
      blinkB_next = blinkB_reg;
      if (!running) begin
         comIdx_next = 3'h0;
         pol_next    = 1'b0;
      end else if (lcdTick) begin
         if (comIdx_reg >= lastCom(slices)) begin
            comIdx_next = 3'h0;
            pol_next    = !pol_reg;
         end else begin
            comIdx_next = comIdx_reg + 3'h1;
         end
      end
      // phase tracks live bits so a change needs no restart
      if (!mode1_reg[M1_BLINK]) begin
         blinkB_next = mode1_reg[M1_AREA];
      end else if (rtcPeriodicInterrupt) begin
         blinkB_next = !blinkB_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         comIdx_reg <= 3'h0;
         pol_reg    <= 1'b0;
         blinkB_reg <= 1'b0;
      end else begin
         comIdx_reg <= comIdx_next;
         pol_reg    <= pol_next;
         blinkB_reg <= blinkB_next;
      end
   end

   // area choice only exists in the narrow modes
   assign showB = blinkB_reg && !wideMode(slices);

   // ---------------- pin levels ----------------
   logic [NUM_COM-1:0] comSel_reg;
   logic [NUM_COM-1:0] comSel_next;
   logic [NUM_COM-1:0] comEn_reg;
   logic [NUM_COM-1:0] comEn_next;
   logic [NUM_SEG-1:0] segSel_reg;
   logic [NUM_SEG-1:0] segSel_next;
   logic [NUM_SEG-1:0] segEn_reg;
   logic [NUM_SEG-1:0] segEn_next;
   logic               polOut_reg;
   logic [2:0]         bitIdx;

   always_comb begin
      comSel_next = '0;
      comEn_next  = '0;
      segSel_next = '0;
      segEn_next  = '0;
      bitIdx      = comIdx_reg;
      if (!wideMode(slices) && showB) begin
         bitIdx = comIdx_reg + 3'h4;
      end
      if (running) begin
         // which commons carry a waveform
         for (int j = 0; j < NUM_COM; j++) begin
            comEn_next[j] = (slices == SL_STATIC && j < 4) ||
                            (32'(j) <= 32'(lastCom(slices)));
         end
         // shared pins are commons in wide modes, else segments
         for (int i = 0; i < NUM_SEG; i++) begin
            segEn_next[i] = !(wideMode(slices) && i < 4);
         end
         if (!mode1_reg[M1_DISPON]) begin
            comSel_next = comEn_next;
         end else begin
            for (int j = 0; j < NUM_COM; j++) begin
               comSel_next[j] = comEn_next[j] &&
                  ((slices == SL_STATIC) || 3'(j) == comIdx_reg);
            end
            for (int i = 0; i < NUM_SEG; i++) begin
               // bit one selects, bit zero deselects
               segSel_next[i] = segEn_next[i] &&
                                dispData_reg[i][bitIdx];
            end
         end
      end
   end

   // pin levels come from flip-flops so they change cleanly
   always_ff @(posedge core_clk) begin
      if (rst) begin
         comSel_reg <= '0;
         comEn_reg  <= '0;
         segSel_reg <= '0;
         segEn_reg  <= '0;
         polOut_reg <= 1'b0;
      end else begin
         comSel_reg <= comSel_next;
         comEn_reg  <= comEn_next;
         segSel_reg <= segSel_next;
         segEn_reg  <= segEn_next;
         polOut_reg <= pol_reg;
      end
   end

   assign comSelect     = comSel_reg;
   assign comEnable     = comEn_reg;
   assign segSelect     = segSel_reg;
   assign segEnable     = segEn_reg;
   assign levelPolarity = polOut_reg;
endmodule

/* verif/sld_drive_ctrl_chk.sv */
`timescale 1ns/10ps
module sld_drive_ctrl_chk
   import sld_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  comSelect,
   input wire logic [7:0]  comEnable,
   input wire logic [41:0] segSelect,
   input wire logic [41:0] segEnable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // access phase of an apb transfer
   wire logic acc;
   wire logic m0Wr;
   assign acc = psel && penable;
   assign m0Wr = acc && pwrite && paddr == OFS_MODE0;
   a_pready_zero: assert property (acc |-> pready)
      else $error("pready low in access phase");
   a_unmapped_err: assert property (acc && paddr == 12'h010 |->
      pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   a_boost_bias: assert property (m0Wr && pwdata[1:0] == DM_BOOST &&
      pwdata[7:6] == BIAS_HALF |-> pslverr) else $error("boost half bias taken");
   a_split_bias: assert property (m0Wr && pwdata[1:0] == DM_SPLIT &&
      pwdata[7:6] != BIAS_THIRD |-> pslverr) else $error("split bias taken");
   a_com_used: assert property ((comSelect & ~comEnable) == 8'h00)
      else $error("unused common selected");
   a_com_table: assert property (comEnable inside
      {8'h00, 8'h03, 8'h07, 8'h0f, 8'h3f, 8'hff})
      else $error("common enable pattern illegal");
   a_com_order: assert property ($onehot0(comSelect) ||
      comSelect == comEnable) else $error("commons not selected in turn");
   a_seg_shared: assert property (comEnable[4] |->
      segEnable[3:0] == 4'h0) else $error("shared pin used twice");
   a_seg_unused: assert property ((segSelect & ~segEnable) == 42'h0)
      else $error("select on undriven segment");
   a_stop_dark: assert property (comEnable == 8'h00 |->
      segEnable == 42'h0 && comSelect == 8'h00) else $error("pins live when off");
   // a stuck scan would burn one row; divider 7 still moves within 600
   a_scan_moves: assert property ($onehot(comSelect) |-> ##[1:600]
      (comSelect != $past(comSelect) || comEnable == 8'h00))
      else $error("common scan stalled");
   c_eight_scan: cover property (comEnable == 8'hff && $onehot(comSelect));
   c_refused: cover property (acc && pslverr);
   c_lit_row: cover property (comSelect[0] && segSelect != 42'h0);
endmodule
bind sld_drive_ctrl sld_drive_ctrl_chk sld_drive_ctrl_chk_i(
   .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .comSelect(comSelect),
   .comEnable(comEnable), .segSelect(segSelect), .segEnable(segEnable));

/* verif/sld_panel_model.sv */
`timescale 1ns/10ps
module sld_panel_model (
   input wire logic        core_clk,
   input wire logic [7:0]  comSelect,
   input wire logic [41:0] segSelect,
   input wire logic [41:0] segEnable,
   input wire logic        levelPolarity,
   output logic     [41:0] lit [8],
   output int              flips
);
   logic polLast = 1'b0;
   int   swaps = 0;
   assign flips = swaps;
   // a pixel darkens where its row is selected and its column selected
   always @(posedge core_clk) begin
      if ($onehot(comSelect)) begin
         for (int c = 0; c < 8; c++) begin
            if (comSelect[c]) lit[c] <= segSelect & segEnable;
         end
      end
      // count polarity swaps; a panel with none would age from dc
      if (levelPolarity !== polLast) swaps <= swaps + 1;
      polLast <= levelPolarity;
   end
endmodule

/* verif/sld_drive_ctrl_bench.sv */
`timescale 1ns/10ps
module sld_drive_ctrl_bench;
   import sld_pkg::*;
   localparam int SETUP = 20;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        rtc = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  comSelect;
   logic [7:0]  comEnable;
   logic [41:0] segSelect;
   logic [41:0] segEnable;
   logic        levelPolarity;
   logic        boostEnable;
   logic        supplyRange;
   logic [1:0]  driveMethod;
   logic [1:0]  biasSelect;
   logic        waveformType;
   logic [41:0] lit [8];
   int          flips;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   logic [7:0]  tab [6] = '{8'h0f, 8'h03, 8'h07, 8'h0f, 8'h3f, 8'hff};
   always #50 core_clk = ~core_clk;
   sld_drive_ctrl sld_drive_ctrl_i(.core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rtcPeriodicInterrupt(rtc), .comSelect(comSelect),
      .comEnable(comEnable), .segSelect(segSelect), .segEnable(segEnable),
      .levelPolarity(levelPolarity), .boostEnable(boostEnable),
      .supplyRange(supplyRange), .driveMethod(driveMethod),
      .biasSelect(biasSelect), .waveformType(waveformType));
   sld_panel_model sld_panel_model_i(.core_clk(core_clk),
      .comSelect(comSelect), .segSelect(segSelect), .segEnable(segEnable),
      .levelPolarity(levelPolarity), .lit(lit), .flips(flips));
   function automatic logic [7:0] pat(input int i);
      return 8'(i * 37 + 5);
   endfunction
   function automatic logic [31:0] m0(input logic [2:0] s,
      input logic [1:0] b, input logic [1:0] dm);
      return {24'h0, b, s, 1'b0, dm};
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] ed, input logic ee);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      if (!w) chk(prdata, ed);
      chk(pslverr, ee);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // compare each captured row with the stored byte bits
   task automatic frame(input int sh, input int nc, input int lo);
      logic [41:0] e;
      logic [7:0]  p;
      @(negedge core_clk);
      for (int c = 0; c < nc; c++) begin
         for (int i = 0; i < 42; i++) begin
            p = pat(i);
            e[i] = (i >= lo) ? p[c + sh] : 1'b0;
         end
         chk(lit[c], e);
      end
   endtask
   task automatic pulse;
      @(posedge core_clk);
      rtc <= 1'b1;
      @(posedge core_clk);
      rtc <= 1'b0;
      repeat (40) @(posedge core_clk);
   endtask
   // hang guard, far above the several hundred cycles the run needs
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results;
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      xfer(0, OFS_MODE0, 0, {24'h0, M0_RESET}, 0);
      xfer(0, OFS_MODE1, 0, {24'h0, M1_RESET}, 0);
      xfer(0, OFS_CLKCTL, 0, {29'h0, CLK_RESET}, 0);
      xfer(0, 12'h010, 0, 0, 1);
      xfer(1, OFS_MODE1, 32'h01, 0, 0);
      xfer(1, OFS_MODE0, m0(SL_FOUR, BIAS_HALF, DM_BOOST), 0, 1);
      xfer(1, OFS_MODE0, m0(SL_FOUR, BIAS_QUARTER, DM_SPLIT), 0, 1);
      xfer(1, OFS_MODE0, m0(SL_FOUR, BIAS_THIRD, DM_SPLIT), 0, 0);
      xfer(1, OFS_MODE0, m0(SL_FOUR, BIAS_QUARTER, DM_BOOST), 0, 0);
      xfer(0, OFS_MODE0, 0, m0(SL_FOUR, BIAS_QUARTER, DM_BOOST), 0);
      chk({driveMethod, biasSelect, waveformType},
          {DM_BOOST, BIAS_QUARTER, 1'b0});
      for (int i = 0; i < 42; i++) xfer(1, OFS_DATA + 12'(4 * i), pat(i), 0, 0);
      xfer(1, OFS_CLKCTL, 0, 0, 0);
      repeat (SETUP) @(posedge core_clk);
      xfer(1, OFS_MODE1, 32'h03, 0, 0);
      @(negedge core_clk);
      chk({boostEnable, supplyRange}, 2'b11);
      for (int s = 0; s < 6; s++) begin
         xfer(1, OFS_MODE0, m0(3'(s), BIAS_THIRD, DM_BOOST), 0, 0);
         xfer(1, OFS_MODE1, 32'h13, 0, 0);
         repeat (3) @(posedge core_clk);
         chk(comEnable, tab[s]);
         chk(comSelect, tab[s]);
         chk(segSelect, 0);
         chk(segEnable, s >= 4 ? 42'h3fffffffff0 : 42'h3ffffffffff);
         xfer(1, OFS_MODE1, 32'h03, 0, 0);
         repeat (3) @(posedge core_clk);
         chk({comEnable, segEnable}, 0);
      end
      xfer(1, OFS_MODE0, m0(SL_FOUR, BIAS_THIRD, DM_BOOST), 0, 0);
      xfer(1, OFS_MODE1, 32'h33, 0, 0);
      repeat (40) @(posedge core_clk);
      frame(0, 4, 0);
      xfer(1, OFS_MODE1, 32'h3b, 0, 0);
      repeat (40) @(posedge core_clk);
      frame(4, 4, 0);
      // blink keeps the B phase it had until the first rtc pulse
      xfer(1, OFS_MODE1, 32'h37, 0, 0);
      repeat (40) @(posedge core_clk);
      frame(4, 4, 0);
      pulse;
      frame(0, 4, 0);
      pulse;
      frame(4, 4, 0);
      xfer(1, OFS_MODE1, 32'h0b, 0, 0);
      xfer(0, OFS_STATUS, 0, 32'h2, 0);
      xfer(1, OFS_MODE0, m0(SL_EIGHT, BIAS_QUARTER, DM_BOOST), 0, 0);
      xfer(1, OFS_MODE1, 32'h3f, 0, 0);
      repeat (60) @(posedge core_clk);
      frame(0, 8, 4);
      chk(flips != 0, 1);
      xfer(1, OFS_MODE1, 32'h0b, 0, 0);
      xfer(0, OFS_STATUS, 0, 32'h0, 0);
      xfer(1, OFS_MODE1, 32'h01, 0, 0);
      @(negedge core_clk);
      chk(boostEnable, 0);
      results;
   end
endmodule
